// [sim/asq_sar_model.sv]
// Analog multiplexer and SAR comparator model
`timescale 1ns/100ps
module asq_sar_model (
    input wire logic [2:0] mux_sel, // Channel select
    input wire logic [9:0] dac_code, // Trial code
    input wire logic [9:0] lvl [8], // Channel levels
    output logic comp_in // Input at or above trial code
);
    assign comp_in = lvl[mux_sel] >= dac_code;
endmodule : asq_sar_model

// [sim/tb_top.sv]
// Self-checking bench of the ADC scan sequencer
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, rst = 1, wr = 0, rd = 0, tov = 0, pin = 0;
    logic idl = 0, pd = 0, comp, sam, cirq, birq, wake, busy;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, d;
    logic [2:0] msel;
    logic [9:0] dac;
    logic [9:0] lvl [8];
    int n_fail = 0, checks_done = 0, nc, nb, nw, seed = 32'h8eddef55;
    initial forever #4 clk = ~clk;
    asq_adc_scan_sequencer DUT (.SYS_CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TIMER_OVF(tov),
        .EXTERNAL_START_PIN(pin), .IDLE_MODE(idl), .PWR_DOWN(pd),
        .COMP_IN(comp), .MUX_SEL(msel), .SAMPLE(sam), .DAC_CODE(dac),
        .CONV_IRQ(cirq), .BND_IRQ(birq), .WAKE(wake), .BUSY(busy));
    asq_sar_model MDL (.mux_sel(msel), .dac_code(dac), .lvl(lvl),
        .comp_in(comp));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rreg
    // Counts pulses until n interrupts or k cycles
    task automatic run(input int n, input int k);
        nc = 0;
        nb = 0;
        nw = 0;
        for (int i = 0; i < k && (n == 0 || nc < n); i++) begin
            @(posedge clk);
            #1 nc += cirq;
            nb += birq;
            nw += wake;
        end
        if (n > 0 && nc < n) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : run
    task automatic pulse_tov();
        @(posedge clk);
        tov <= 1'b1;
        @(posedge clk);
        tov <= 1'b0;
    endtask : pulse_tov
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // Control word: enabled, rising edge, conversion interrupt on, groups of four when f set
    function automatic logic [15:0] cw(int m, int s, int dv, int f, int b,
                                       int o);
        return 16'(2049 | m << 1 | s << 3 | 32 | f << 6 | dv << 8 | b << 12
            | o << 13);
    endfunction : cw
    function automatic logic bhit(logic [9:0] r, lo, hi, logic o);
        return o ? (r < lo || r > hi) : (r >= lo && r <= hi);
    endfunction : bhit
    initial begin
        logic [15:0] rv [6];
        logic [7:0] ch, bs;
        logic [9:0] lo, hi;
        rv = '{asq_pkg::CTRL_RST, 16'(asq_pkg::CHEN_RST),
            16'(asq_pkg::DUAL_RST), 16'(asq_pkg::BHI_RST),
            16'(asq_pkg::BLO_RST), 16'h0000};
        foreach (lvl[i]) lvl[i] = 10'($random(seed));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rreg(i == 5 ? 4'h7 : 4'(i), d);
            chk(d, rv[i]);
        end
        $display("reset test done");
        for (int it = 0; it < 4; it++) begin
            foreach (lvl[i]) lvl[i] = 10'($random(seed));
            ch = it == 0 ? 8'hFF : 8'($random(seed) | 1);
            lo = 10'($random(seed));
            hi = 10'($random(seed));
            wreg(asq_pkg::A_CHEN, 16'(ch));
            wreg(asq_pkg::A_BLO, 16'(lo));
            wreg(asq_pkg::A_BHI, 16'(hi));
            wreg(asq_pkg::A_BSTA, 16'h00FF);
            wreg(asq_pkg::A_CTRL, cw(0, 1, $random(seed) & 7, it == 0,
                it != 3, it & 1));
            run(it == 0 ? 2 : 1, 3000);
            bs = 8'h00;
            for (int c = 0; c < 8; c++) begin
                if (ch[c]) begin
                    rreg(4'(8 + c), d);
                    chk(d, 16'(lvl[c]));
                    bs[c] = it != 3 && bhit(lvl[c], lo, hi, it & 1);
                end
            end
            rreg(asq_pkg::A_BSTA, d);
            chk(d, 16'(bs));
            chk(16'(nb), 16'($countones(bs)));
            run(0, 60);
            chk(16'(nc), 16'h0000);
            $display("scan test %0d done", it);
        end
        wreg(asq_pkg::A_DUAL, 16'h0052);
        wreg(asq_pkg::A_CTRL, cw(2, 0, 0, 0, 0, 0));
        pulse_tov();
        run(2, 3000);
        wreg(asq_pkg::A_CTRL, 16'h0000);
        for (int p = 0; p < 8; p++) begin
            rreg(4'(8 + p), d);
            chk(d, 16'(lvl[p[0] ? 5 : 2]));
        end
        wreg(asq_pkg::A_CHEN, 16'h0081);
        wreg(asq_pkg::A_CTRL, cw(1, 1, 0, 0, 0, 0));
        run(3, 3000);
        wreg(asq_pkg::A_CTRL, 16'h0000);
        @(posedge clk);
        #1 chk(busy, 1'b0);
        $display("dual and continuous test done");
        wreg(asq_pkg::A_STAT, 16'h0003);
        wreg(asq_pkg::A_CHEN, 16'h0024);
        wreg(asq_pkg::A_CTRL, cw(3, 2, 1, 0, 0, 0));
        idl <= 1'b1;
        @(posedge clk);
        pin <= 1'b1;
        repeat (10) @(posedge clk);
        pin <= 1'b0;
        repeat (10) @(posedge clk);
        pin <= 1'b1;
        run(0, 300);
        chk(16'(nc), 16'h0001);
        chk(16'(nw), 16'h0001);
        rreg(asq_pkg::A_STAT, d);
        chk(d, 16'h0001);
        rreg(4'hA, d);
        chk(d, 16'(lvl[2]));
        wreg(asq_pkg::A_CTRL, cw(3, 0, 1, 0, 0, 0));
        pulse_tov();
        repeat (4) @(posedge clk);
        pulse_tov();
        run(0, 300);
        chk(16'(nc), 16'h0001);
        rreg(4'hD, d);
        chk(d, 16'(lvl[5]));
        $display("step test done");
        pd <= 1'b1;
        pulse_tov();
        run(0, 100);
        chk(16'(nc), 16'h0000);
        chk(busy, 1'b0);
        $display("power test done");
        tally_and_finish();
    end
endmodule : tb_top

// [src/asq_adc_scan_sequencer.sv]
// ADC scan sequencer: start sources, SAR control, limits and registers
`timescale 1ns/100ps
// Contract
// R1: Auto scan single converts each enabled channel once into its own pair.
// R2: Auto scan interrupt after all channels, or after four then the rest.
// R3: One enabled channel in auto scan single acts as fixed single conversion.
// R4: Auto scan continuous restarts at lowest enabled channel without a start.
// R5: Continuous results wrap through the eight result pairs, overwriting.
// R6: Continuous conversion runs until software stops it.
// R7: Dual mode alternates two chosen inputs into pairs 0, 1, 2, 3 onward.
// R8: Dual mode interrupts after each group of four or eight conversions.
// R9: Single step converts one channel, interrupts, then waits for a start.
// R10: Timer overflow starts a conversion; later overflows ignored meanwhile.
// R11: Selecting immediate start launches a conversion at once.
// R12: Chosen edge on the start pin starts; later edges ignored meanwhile.
// R13: Result checked against limits, inside inclusive or outside selectable.
// R14: Boundary enable cleared disables the limit interrupt entirely.
// R15: Outside check on top four bits gives an early interrupt.
// R16: Failing early check, compare again once eight top bits resolve.
// R17: Per channel flag set for each channel raising a boundary interrupt.
// R18: Conversion clock divides system clock by 1 to 8.
// R19: In idle the converter runs and completion wakes if interrupt enabled.
// R20: No conversions in power-down modes.
// R21: Ten bit SAR result from one of eight multiplexed inputs.
// R22: Starts ignored while converting; result bits resolve MSB first.
module asq_adc_scan_sequencer (
    input logic SYS_CLK, // System clock
    input logic RST, // Synchronous reset, high
    input logic [3:0] ADDR, // Register index
    input logic [15:0] WDATA, // Write data
    input logic WR, // Write strobe
    input logic RD, // Read strobe
    output logic [15:0] RDATA, // Read data, cycle after RD
    input logic TIMER_OVF, // Timer overflow pulse
    input logic EXTERNAL_START_PIN, // Start pin, asynchronous
    input logic IDLE_MODE, // Device in idle
    input logic PWR_DOWN, // Device in a power-down mode
    input logic COMP_IN, // Comparator: input at or above DAC
    output logic [2:0] MUX_SEL, // Analog input select
    output logic SAMPLE, // Sample-and-hold track
    output logic [9:0] DAC_CODE, // SAR trial code
    output logic CONV_IRQ, // Conversion interrupt pulse
    output logic BND_IRQ, // Boundary interrupt pulse
    output logic WAKE, // Idle wake-up pulse
    output logic BUSY // Conversion in progress
);
    asq_pkg::asq_state_e state_reg;
    asq_pkg::asq_mode_e mode;
    logic [15:0] ctrl_reg;
    logic [7:0] chen_reg;
    logic [7:0] dual_reg;
    logic [9:0] bhi_reg;
    logic [9:0] blo_reg;
    logic [9:0] res_mem [0:7];
    logic [7:0] bsta_reg;
    logic cdone_reg;
    logic bhit_reg;
    logic [2:0] ch_reg;
    logic [2:0] dst_reg;
    logic [2:0] cnt_reg;
    logic [2:0] div_reg;
    logic [9:0] dac_reg;
    logic [3:0] bit_reg;
    logic phase_reg;
    logic bdone_reg;
    logic imm_reg;
    logic [2:0] pin_sync_reg;
    logic pin_lvl_reg;
    logic conv_irq_reg;
    logic bnd_irq_reg;
    logic wake_reg;
    logic [15:0] rdata_reg;
    logic en, cie, bie, outside, four, grp8, rise;
    logic [1:0] src;
    logic [2:0] divsel;
    logic wr_ctrl, edge_ev, start_req, can_start, tick;
    logic sar_tick, conv_end, scan_end, conv_ev, bnd_ev;
    logic chk_out, chk_in;
    logic [9:0] trial;
    logic [9:0] resolved;
    logic [3:0] f_next;
    logic [3:0] f_low;
    logic [3:0] f_here;
    logic [2:0] start_ch;
    logic [2:0] dst_idx;
    logic [7:0] bsta_set;
    logic [15:0] stat_word;

    // Lowest enabled channel at or above from; bit 3 says found
    function automatic logic [3:0] first_ch(input logic [7:0] m,
                                            input logic [2:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && i >= int'(from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : first_ch

    // Masked result lies outside the masked limits
    function automatic logic bnd_out(input logic [9:0] r,
                                     input logic [9:0] h,
                                     input logic [9:0] l,
                                     input logic [9:0] m);
        return ((r & m) > (h & m)) || ((r & m) < (l & m));
    endfunction : bnd_out

    assign en = ctrl_reg[asq_pkg::C_EN];
    assign cie = ctrl_reg[asq_pkg::C_CIE];
    assign bie = ctrl_reg[asq_pkg::C_BIE];
    assign outside = ctrl_reg[asq_pkg::C_OUT];
    assign four = ctrl_reg[asq_pkg::C_FOUR];
    assign grp8 = ctrl_reg[asq_pkg::C_G8];
    assign rise = ctrl_reg[asq_pkg::C_RISE];
    assign src = ctrl_reg[asq_pkg::C_SRC +: 2];
    assign divsel = ctrl_reg[asq_pkg::C_DIV +: 3];
    assign mode = asq_pkg::asq_mode_e'(ctrl_reg[asq_pkg::C_MODE +: 2]);
    assign wr_ctrl = WR && ADDR == asq_pkg::A_CTRL;

    // Configuration registers
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctrl_reg <= asq_pkg::CTRL_RST;
            chen_reg <= asq_pkg::CHEN_RST;
            dual_reg <= asq_pkg::DUAL_RST;
            bhi_reg <= asq_pkg::BHI_RST;
            blo_reg <= asq_pkg::BLO_RST;
        end else if (WR) begin
            if (ADDR == asq_pkg::A_CTRL) begin
                ctrl_reg <= WDATA;
            end else if (ADDR == asq_pkg::A_CHEN) begin
                chen_reg <= WDATA[7:0];
            end else if (ADDR == asq_pkg::A_DUAL) begin
                dual_reg <= WDATA[7:0];
            end else if (ADDR == asq_pkg::A_BHI) begin
                bhi_reg <= WDATA[9:0];
            end else if (ADDR == asq_pkg::A_BLO) begin
                blo_reg <= WDATA[9:0];
            end
        end
    end

    // R11 immediate start
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            imm_reg <= 1'b0;
        end else if (wr_ctrl) begin
            imm_reg <= WDATA[asq_pkg::C_EN]
                       && WDATA[asq_pkg::C_SRC +: 2] == asq_pkg::S_IMM;
        end else begin
            // Held over the OFF to ARM step, dropped if busy
            imm_reg <= imm_reg && state_reg == asq_pkg::ST_OFF;
        end
    end

    // Start pin synchroniser
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pin_sync_reg <= 3'h0;
            pin_lvl_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], EXTERNAL_START_PIN};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pin_lvl_reg <= pin_sync_reg[2];
            end
        end
    end

    // R12 edge select
    assign edge_ev = pin_sync_reg[1] == pin_sync_reg[2]
                     && pin_sync_reg[2] != pin_lvl_reg
                     && pin_sync_reg[2] == rise;
    // R10 timer start
    assign start_req = (src == asq_pkg::S_TMR && TIMER_OVF) || imm_reg
                       || (src == asq_pkg::S_EDGE && edge_ev);

    // R18 conversion clock divider
    assign tick = div_reg == divsel;
    always_ff @(posedge SYS_CLK) begin
        if (RST || tick || state_reg == asq_pkg::ST_OFF
            || state_reg == asq_pkg::ST_ARM) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= 3'(div_reg + 3'h1);
        end
    end

    // R22 comparator decides the trial bit
    assign trial = asq_pkg::SAR_ONE << bit_reg;
    assign resolved = COMP_IN ? dac_reg : (dac_reg & ~trial);
    assign sar_tick = state_reg == asq_pkg::ST_CONV && tick;
    assign conv_end = sar_tick && bit_reg == asq_pkg::SAR_LSB;

    assign f_next = first_ch(chen_reg, 3'(ch_reg + 3'h1));
    assign f_low = first_ch(chen_reg, 3'h0);
    assign f_here = first_ch(chen_reg, ch_reg);
    assign scan_end = ch_reg == asq_pkg::LAST_CH || !f_next[3];
    // R20 power-down blocks starts; R22 starts only taken when armed
    assign can_start = state_reg == asq_pkg::ST_ARM && start_req
                       && !PWR_DOWN && (mode == asq_pkg::M_DUAL || f_low[3]);
    assign start_ch = mode == asq_pkg::M_DUAL ? dual_reg[asq_pkg::D_A +: 3]
                    : (mode == asq_pkg::M_STEP && f_here[3]) ? f_here[2:0]
                    : f_low[2:0];

    // Sequencer
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= asq_pkg::ST_OFF;
            ch_reg <= 3'h0;
            dst_reg <= 3'h0;
            cnt_reg <= 3'h0;
            phase_reg <= 1'b0;
            dac_reg <= 10'h000;
            bit_reg <= 4'h0;
        end else if (!en) begin
            // R6 clearing the enable bit returns the converter to OFF
            state_reg <= asq_pkg::ST_OFF;
            ch_reg <= 3'h0;
        end else if (PWR_DOWN && (state_reg == asq_pkg::ST_SAMP
                     || state_reg == asq_pkg::ST_CONV)) begin
            // R20 abort in power-down
            state_reg <= asq_pkg::ST_ARM;
        end else begin
            case (state_reg)
                asq_pkg::ST_OFF: begin
                    state_reg <= asq_pkg::ST_ARM;
                end
                asq_pkg::ST_ARM: begin
                    if (can_start) begin
                        state_reg <= asq_pkg::ST_SAMP;
                        ch_reg <= start_ch;
                        phase_reg <= 1'b0;
                        dst_reg <= 3'h0;
                        cnt_reg <= 3'h0;
                    end
                end
                asq_pkg::ST_SAMP: begin
                    if (tick) begin
                        // R21 ten bit SAR from mid scale
                        state_reg <= asq_pkg::ST_CONV;
                        dac_reg <= asq_pkg::DAC_MID;
                        bit_reg <= asq_pkg::SAR_MSB;
                    end
                end
                asq_pkg::ST_CONV: begin
                    if (tick && bit_reg != asq_pkg::SAR_LSB) begin
                        // R22 MSB first
                        dac_reg <= resolved | (trial >> 1);
                        bit_reg <= 4'(bit_reg - 4'h1);
                    end else if (tick) begin
                        dac_reg <= resolved;
                        case (mode)
                            asq_pkg::M_DUAL: begin
                                // R7 alternate inputs, next pair
                                ch_reg <= phase_reg
                                          ? dual_reg[asq_pkg::D_A +: 3]
                                          : dual_reg[asq_pkg::D_B +: 3];
                                phase_reg <= !phase_reg;
                                dst_reg <= 3'(dst_reg + 3'h1);
                                state_reg <= asq_pkg::ST_SAMP;
                            end
                            asq_pkg::M_STEP: begin
                                // R9 pause after one channel
                                ch_reg <= scan_end ? 3'h0
                                          : 3'(ch_reg + 3'h1);
                                state_reg <= asq_pkg::ST_ARM;
                            end
                            asq_pkg::M_SCANC: begin
                                // R4 restart from lowest channel
                                cnt_reg <= scan_end ? 3'h0
                                           : 3'(cnt_reg + 3'h1);
                                ch_reg <= scan_end ? f_low[2:0]
                                          : f_next[2:0];
                                state_reg <= asq_pkg::ST_SAMP;
                            end
                            default: begin
                                // R1 R3 one pass over enabled channels
                                cnt_reg <= 3'(cnt_reg + 3'h1);
                                ch_reg <= f_next[2:0];
                                state_reg <= scan_end ? asq_pkg::ST_ARM
                                             : asq_pkg::ST_SAMP;
                            end
                        endcase
                    end
                end
                default: begin
                    state_reg <= asq_pkg::ST_OFF;
                end
            endcase
        end
    end

    // R5 pairs follow channel, dual uses wrapping pair counter
    assign dst_idx = mode == asq_pkg::M_DUAL ? dst_reg : ch_reg;
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                res_mem[i] <= 10'h000;
            end
        end else if (conv_end) begin
            res_mem[dst_idx] <= resolved;
        end
    end

    // R2 R8 R9 conversion interrupt grouping
    assign conv_ev = conv_end && (mode == asq_pkg::M_STEP
        || (mode == asq_pkg::M_DUAL
            ? (grp8 ? dst_reg == asq_pkg::LAST_CH
                    : dst_reg[1:0] == asq_pkg::FOUR_IDX[1:0])
            : (scan_end || (four && cnt_reg == asq_pkg::FOUR_IDX))));

    // R13 R15 R16 limit checks, R14 gated by enable
    assign chk_out = bie && outside
        && ((bit_reg == asq_pkg::EARLY4
             && bnd_out(resolved, bhi_reg, blo_reg, asq_pkg::MSK4))
         || (bit_reg == asq_pkg::EARLY8
             && bnd_out(resolved, bhi_reg, blo_reg, asq_pkg::MSK8))
         || (bit_reg == asq_pkg::SAR_LSB
             && bnd_out(resolved, bhi_reg, blo_reg, asq_pkg::MSK10)));
    assign chk_in = bie && !outside && bit_reg == asq_pkg::SAR_LSB
        && !bnd_out(resolved, bhi_reg, blo_reg, asq_pkg::MSK10);
    assign bnd_ev = sar_tick && !bdone_reg && (chk_out || chk_in);
    assign bsta_set = bnd_ev ? (8'h01 << ch_reg) : 8'h00;

    // One boundary interrupt per conversion
    always_ff @(posedge SYS_CLK) begin
        if (RST || state_reg == asq_pkg::ST_SAMP) begin
            bdone_reg <= 1'b0;
        end else if (bnd_ev) begin
            bdone_reg <= 1'b1;
        end
    end

    // R19 interrupt and wake pulses
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            conv_irq_reg <= 1'b0;
            bnd_irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            conv_irq_reg <= conv_ev && cie;
            bnd_irq_reg <= bnd_ev;
            wake_reg <= conv_ev && cie && IDLE_MODE;
        end
    end

    // R17 sticky flags, set beats write-one-to-clear
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cdone_reg <= 1'b0;
            bhit_reg <= 1'b0;
            bsta_reg <= 8'h00;
        end else begin
            cdone_reg <= conv_ev || (cdone_reg && !(WR
                && ADDR == asq_pkg::A_STAT && WDATA[asq_pkg::S_CDONE]));
            bhit_reg <= bnd_ev || (bhit_reg && !(WR
                && ADDR == asq_pkg::A_STAT && WDATA[asq_pkg::S_BHIT]));
            bsta_reg <= bsta_set | (bsta_reg
                & ~((WR && ADDR == asq_pkg::A_BSTA) ? WDATA[7:0] : 8'h00));
        end
    end

    assign stat_word = {13'h0000, BUSY, bhit_reg, cdone_reg};

    // Read port, data only in the cycle after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (RST || !RD) begin
            rdata_reg <= 16'h0000;
        end else if (ADDR == asq_pkg::A_CTRL) begin
            rdata_reg <= ctrl_reg;
        end else if (ADDR == asq_pkg::A_CHEN) begin
            rdata_reg <= {8'h00, chen_reg};
        end else if (ADDR == asq_pkg::A_DUAL) begin
            rdata_reg <= {8'h00, dual_reg};
        end else if (ADDR == asq_pkg::A_BHI) begin
            rdata_reg <= {6'h00, bhi_reg};
        end else if (ADDR == asq_pkg::A_BLO) begin
            rdata_reg <= {6'h00, blo_reg};
        end else if (ADDR == asq_pkg::A_STAT) begin
            rdata_reg <= stat_word;
        end else if (ADDR == asq_pkg::A_BSTA) begin
            rdata_reg <= {8'h00, bsta_reg};
        end else if (ADDR[3]) begin
            rdata_reg <= {6'h00, res_mem[ADDR[2:0]]};
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign RDATA = rdata_reg;
    assign MUX_SEL = ch_reg;
    assign DAC_CODE = dac_reg;
    assign SAMPLE = state_reg == asq_pkg::ST_SAMP;
    assign BUSY = state_reg == asq_pkg::ST_SAMP
                  || state_reg == asq_pkg::ST_CONV;
    assign CONV_IRQ = conv_irq_reg;
    assign BND_IRQ = bnd_irq_reg;
    assign WAKE = wake_reg;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_div_two;
        !tick ##1 tick;
    endsequence
    sequence s_sar_begin;
        state_reg == asq_pkg::ST_CONV && bit_reg == asq_pkg::SAR_MSB
        && dac_reg == asq_pkg::DAC_MID;
    endsequence

    // R9 step pause
    AST_STEP_PAUSE: assert property ( // R9
        mode == asq_pkg::M_STEP && conv_end && en && !PWR_DOWN
        |=> state_reg == asq_pkg::ST_ARM)
        else $error("step mode did not pause");
    // R4 continuous restart
    AST_SCAN_WRAP: assert property ( // R4
        mode == asq_pkg::M_SCANC && conv_end && scan_end && en && !PWR_DOWN
        |=> state_reg == asq_pkg::ST_SAMP && ch_reg == $past(f_low[2:0]))
        else $error("continuous scan did not restart");
    // R7 dual pair order
    AST_DUAL_PAIR: assert property ( // R7
        mode == asq_pkg::M_DUAL && conv_end && en && !PWR_DOWN
        |=> dst_reg == 3'($past(dst_reg) + 3'h1))
        else $error("dual pair did not advance");
    // R1 result stored
    AST_RESULT: assert property ( // R1
        conv_end && mode == asq_pkg::M_SCAN1
        |=> res_mem[$past(ch_reg)] == $past(resolved))
        else $error("result not stored in channel pair");
    // R14 boundary gate
    AST_BND_GATE: assert property ( // R14
        BND_IRQ |-> $past(bie))
        else $error("boundary interrupt while disabled");
    // R20 power-down halts
    AST_PWR_DOWN: assert property ( // R20
        PWR_DOWN |=> !BUSY)
        else $error("conversion running in power-down");
    // R18 divide by two
    AST_DIV_TWO: assert property ( // R18
        sar_tick && divsel == 3'h1 && bit_reg != asq_pkg::SAR_LSB
        && !wr_ctrl && !PWR_DOWN ##1 !wr_ctrl |-> s_div_two)
        else $error("conversion clock ratio wrong");
    // R21 SAR starts mid scale
    AST_SAR_START: assert property ( // R21
        state_reg == asq_pkg::ST_SAMP && tick && en && !PWR_DOWN
        |=> s_sar_begin ##0 SAMPLE == 1'b0)
        else $error("SAR did not start at mid scale");
    // R22 start ignored while busy
    AST_BUSY_IGN: assert property ( // R22
        state_reg == asq_pkg::ST_CONV && start_req && !conv_end
        |=> state_reg != asq_pkg::ST_SAMP)
        else $error("start accepted during conversion");
    // R15 early interrupt
    AST_EARLY: assert property ( // R15
        sar_tick && bit_reg == asq_pkg::EARLY4 && bie && outside
        && !bdone_reg
        && bnd_out(resolved, bhi_reg, blo_reg, asq_pkg::MSK4)
        |=> BND_IRQ ##1 !BND_IRQ)
        else $error("early boundary interrupt missing");
endmodule : asq_adc_scan_sequencer

// [src/asq_pkg.sv]
// Shared constants, register map and state codes of the ADC scan sequencer
package asq_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_CHEN = 4'h1;
    localparam logic [3:0] A_DUAL = 4'h2;
    localparam logic [3:0] A_BHI = 4'h3;
    localparam logic [3:0] A_BLO = 4'h4;
    localparam logic [3:0] A_STAT = 4'h5;
    localparam logic [3:0] A_BSTA = 4'h6;
    // Control word, dual select and status word fields
    localparam int C_EN = 0;
    localparam int C_MODE = 1;
    localparam int C_SRC = 3;
    localparam int C_RISE = 5;
    localparam int C_FOUR = 6;
    localparam int C_G8 = 7;
    localparam int C_DIV = 8;
    localparam int C_CIE = 11;
    localparam int C_BIE = 12;
    localparam int C_OUT = 13;
    localparam int D_A = 0;
    localparam int D_B = 4;
    localparam int S_CDONE = 0;
    localparam int S_BHIT = 1;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [7:0] CHEN_RST = 8'h00;
    localparam logic [7:0] DUAL_RST = 8'h10;
    localparam logic [9:0] BHI_RST = 10'h3FF;
    localparam logic [9:0] BLO_RST = 10'h000;
    // Start sources
    localparam logic [1:0] S_TMR = 2'h0;
    localparam logic [1:0] S_IMM = 2'h1;
    localparam logic [1:0] S_EDGE = 2'h2;
    // Successive approximation, last channel and group-of-four figures
    localparam logic [3:0] SAR_MSB = 4'h9;
    localparam logic [3:0] SAR_LSB = 4'h0;
    localparam logic [3:0] EARLY4 = 4'h6;
    localparam logic [3:0] EARLY8 = 4'h2;
    localparam logic [9:0] DAC_MID = 10'h200;
    localparam logic [9:0] SAR_ONE = 10'h001;
    localparam logic [9:0] MSK4 = 10'h3C0;
    localparam logic [9:0] MSK8 = 10'h3FC;
    localparam logic [9:0] MSK10 = 10'h3FF;
    localparam logic [2:0] LAST_CH = 3'h7;
    localparam logic [2:0] FOUR_IDX = 3'h3;
    typedef enum logic [1:0] {
        M_SCAN1 = 2'h0,
        M_SCANC = 2'h1,
        M_DUAL = 2'h2,
        M_STEP = 2'h3
    } asq_mode_e;
    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_ARM = 2'h1,
        ST_SAMP = 2'h2,
        ST_CONV = 2'h3
    } asq_state_e;
endpackage : asq_pkg
